// ---- rtl/uwbs_consts.svh ----
// Offsets, field positions, reset values and rate constants of the serial port.
// Assumes inclusion by bare name from the design files of this block.
`ifndef UWBS_CONSTS_SVH
`define UWBS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------------
`define UWBS_CTRL_IDX 16'hc0e0
`define UWBS_STAT_IDX 16'hc0e2
`define UWBS_DATA_IDX 16'hc0e4
`define UWBS_EVT_IDX 16'hc100
`define UWBS_MASK_IDX 16'hc102

// ----------------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------------
`define UWBS_CTRL_EN_BIT 0
`define UWBS_CTRL_BAUD_LSB 1
`define UWBS_CTRL_DIVIDE_BY_EIGHT_SELECT_BIT 4
`define UWBS_CTRL_WMASK 16'h001f
`define UWBS_CTRL_RESET 16'h0007
`define UWBS_STAT_TXF_BIT 0
`define UWBS_STAT_RXF_BIT 1
`define UWBS_EVT_TXDONE_BIT 0
`define UWBS_EVT_RXDONE_BIT 1

// ----------------------------------------------------------------------------
// Rates: system clock, oversampling and undivided baud rates per code.
// ----------------------------------------------------------------------------
`define UWBS_CLK_HZ 40000000
`define UWBS_OVERSAMPLE 16
`define UWBS_DIVIDE_BY_EIGHT_SELECT_SHIFT 3
`define UWBS_BAUD_0 115200
`define UWBS_BAUD_1 57600
`define UWBS_BAUD_2 38400
`define UWBS_BAUD_3 28800
`define UWBS_BAUD_4 19200
`define UWBS_BAUD_5 14400
`define UWBS_BAUD_6 9600
`define UWBS_BAUD_7 7200

`endif

// ---- rtl/uwbs_pkg.sv ----
// Types shared by the serial port modules.
// Assumes nothing of its surroundings.
package uwbs_pkg;
    typedef enum logic [1:0] {
        UWBS_IDLE = 2'b00,
        UWBS_START = 2'b01,
        UWBS_DATA = 2'b10,
        UWBS_STOP = 2'b11
    } uwbs_state_type;
endpackage

// ---- rtl/uwbs_baud_gen.sv ----
// Oversampling tick generator for the serial port.
// Assumes ref_clk at CLK_HZ and a synchronous active-high reset.
`timescale 1ns/1ps
`include "uwbs_consts.svh"

module uwbs_baud_gen #(
    parameter int CLK_HZ = `UWBS_CLK_HZ
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic [2:0] rate_code,
    input wire logic divide_by_eight_select,
    output logic tick
);
    import uwbs_pkg::*;

    localparam int BAUD_HZ [8] = '{`UWBS_BAUD_0, `UWBS_BAUD_1, `UWBS_BAUD_2, `UWBS_BAUD_3,
                                   `UWBS_BAUD_4, `UWBS_BAUD_5, `UWBS_BAUD_6, `UWBS_BAUD_7};

    // Rounded to the nearest count so the rate error stays small at a 40 MHz clock.
    function automatic logic [11:0] base_div(input logic [2:0] code);
        base_div = 12'((CLK_HZ + BAUD_HZ[code] * (`UWBS_OVERSAMPLE / 2)) /
                       (BAUD_HZ[code] * `UWBS_OVERSAMPLE));
    endfunction

    logic [14:0] divisor;
    logic [14:0] cnt;
    logic [14:0] next_cnt;
    logic next_tick;

    always_comb begin
        divisor = {3'b000, base_div(rate_code)};
        if (divide_by_eight_select) begin
            divisor = divisor << `UWBS_DIVIDE_BY_EIGHT_SELECT_SHIFT;
        end
        next_cnt = cnt;
        next_tick = 1'b0;
        if (!enable) begin
            next_cnt = 15'h0000;
        end else if (cnt >= divisor - 15'h0001) begin
            next_cnt = 15'h0000;
            next_tick = 1'b1;
        end else begin
            next_cnt = cnt + 15'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt <= 15'h0000;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end

    property p_divide_by_eight_select_scales;
        @(posedge ref_clk) disable iff (rst)
        divide_by_eight_select |-> divisor == {base_div(rate_code), 3'b000};
    endproperty
    a_divide_by_eight_select_scales: assert property (p_divide_by_eight_select_scales)
        else $error("Prescaler does not divide the rate by eight.");

    // Tick count of code 011 at whatever clock rate the port is built for.
    localparam int CODE3_DIV = (CLK_HZ + `UWBS_BAUD_3 * (`UWBS_OVERSAMPLE / 2)) /
                               (`UWBS_BAUD_3 * `UWBS_OVERSAMPLE);

    property p_code3_count;
        @(posedge ref_clk) disable iff (rst)
        (rate_code == 3'b011 && !divide_by_eight_select) |-> divisor == 15'(CODE3_DIV);
    endproperty
    a_code3_count: assert property (p_code3_count)
        else $error("Rate code 011 does not give 28.8k baud.");
endmodule

// ---- rtl/uwbs_rx.sv ----
// Receiver: samples a start bit, eight data bits LSB first and a stop bit.
// Assumes the receive line is synchronous to ref_clk and idles high.
`timescale 1ns/1ps
`include "uwbs_consts.svh"

module uwbs_rx (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic tick,
    input wire logic rx_line,
    output logic [7:0] rx_byte,
    output logic rx_done
);
    import uwbs_pkg::*;

    uwbs_state_type state;
    uwbs_state_type next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [2:0] bit_idx;
    logic [2:0] next_bit_idx;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [7:0] next_rx_byte;
    logic next_rx_done;

    // Every bit is sampled at its middle, eight ticks after its own leading edge.
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_bit_idx = bit_idx;
        next_shreg = shreg;
        next_rx_byte = rx_byte;
        next_rx_done = 1'b0;
        if (!enable) begin
            next_state = UWBS_IDLE;
        end else if (tick) begin
            next_cnt = 4'(cnt + 4'h1);
            case (state)
                UWBS_IDLE: begin
                    next_cnt = 4'h0;
                    if (!rx_line) begin
                        next_state = UWBS_START;
                    end
                end
                UWBS_START: begin
                    if (cnt == 4'h7) begin
                        next_cnt = 4'h0;
                        next_bit_idx = 3'h0;
                        next_state = rx_line ? UWBS_IDLE : UWBS_DATA;
                    end
                end
                UWBS_DATA: begin
                    if (cnt == 4'hf) begin
                        next_shreg = {rx_line, shreg[7:1]};
                        next_bit_idx = 3'(bit_idx + 3'h1);
                        if (bit_idx == 3'h7) begin
                            next_state = UWBS_STOP;
                        end
                    end
                end
                UWBS_STOP: begin
                    if (cnt == 4'hf) begin
                        next_state = UWBS_IDLE;
                        // A missing stop bit drops the character.
                        if (rx_line) begin
                            next_rx_byte = shreg;
                            next_rx_done = 1'b1;
                        end
                    end
                end
                default: begin
                    next_state = UWBS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= UWBS_IDLE;
            cnt <= 4'h0;
            bit_idx <= 3'h0;
            shreg <= 8'h00;
            rx_byte <= 8'h00;
            rx_done <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            bit_idx <= next_bit_idx;
            shreg <= next_shreg;
            rx_byte <= next_rx_byte;
            rx_done <= next_rx_done;
        end
    end
endmodule

// ---- rtl/uwbs_top.sv ----
// Serial port with rate select: register file, transmitter and interrupt logic.
// Assumes an Avalon-MM master on ref_clk and line inputs synchronous to ref_clk.
`timescale 1ns/1ps
`include "uwbs_consts.svh"

module uwbs_top #(
    parameter int CLK_HZ = `UWBS_CLK_HZ
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [17:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic serial_irq_enable,
    output logic cpu_irq_rx_full,
    output logic cpu_irq_tx_empty,
    output logic irq,
    output logic general_pin_transmit_side_out,
    output logic general_pin_transmit_side_oe,
    input wire logic general_pin_receive_side_in
);
    import uwbs_pkg::*;

    function automatic logic reg_hit(input logic [17:0] addr, input logic [15:0] idx);
        reg_hit = (addr == {idx, 2'b00});
    endfunction

    // ------------------------------------------------------------------------
    // Bus slave and registers
    // ------------------------------------------------------------------------
    logic ack;
    logic next_ack;
    logic [4:0] control;
    logic [4:0] next_control;
    logic tx_full;
    logic next_tx_full;
    logic rx_full;
    logic next_rx_full;
    logic [7:0] tx_hold;
    logic [7:0] next_tx_hold;
    logic [1:0] evt;
    logic [1:0] next_evt;
    logic [1:0] mask;
    logic [1:0] next_mask;
    logic [31:0] next_readdata;
    logic wr_go;
    logic rd_go;
    logic port_en;
    logic tick;
    logic [7:0] rx_byte;
    logic rx_done;
    logic tx_done;
    logic [15:0] status_word;

    assign port_en = control[`UWBS_CTRL_EN_BIT];
    // One wait state: the read word is captured before the accepting edge.
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wr_go = avs_write & ack;
    assign rd_go = avs_read & ack;
    assign status_word = {14'h0000, rx_full, tx_full};

    always_comb begin
        next_ack = (avs_read | avs_write) & ~ack;
        next_control = control;
        next_tx_hold = tx_hold;
        next_mask = mask;
        next_readdata = avs_readdata;
        next_tx_full = tx_full;
        next_rx_full = rx_full;
        next_evt = evt;
        if (avs_read && !ack) begin
            next_readdata = 32'h0000_0000;
            if (reg_hit(avs_address, `UWBS_CTRL_IDX)) begin
                next_readdata[4:0] = control;
            end else if (reg_hit(avs_address, `UWBS_STAT_IDX)) begin
                next_readdata[15:0] = status_word;
            end else if (reg_hit(avs_address, `UWBS_DATA_IDX)) begin
                next_readdata[7:0] = rx_byte;
            end else if (reg_hit(avs_address, `UWBS_EVT_IDX)) begin
                next_readdata[1:0] = evt;
            end else if (reg_hit(avs_address, `UWBS_MASK_IDX)) begin
                next_readdata[1:0] = mask;
            end
        end
        if (wr_go && avs_byteenable[0]) begin
            if (reg_hit(avs_address, `UWBS_CTRL_IDX)) begin
                // Only the defined bits are stored; reserved bits read zero.
                next_control = avs_writedata[4:0] & 5'(`UWBS_CTRL_WMASK);
            end else if (reg_hit(avs_address, `UWBS_MASK_IDX)) begin
                next_mask = avs_writedata[1:0];
            end else if (reg_hit(avs_address, `UWBS_EVT_IDX)) begin
                next_evt = evt & ~avs_writedata[1:0];
            end
        end
        // A byte written while one is still pending is dropped, not queued.
        if (wr_go && avs_byteenable[0] && reg_hit(avs_address, `UWBS_DATA_IDX)
                && port_en && !tx_full) begin
            next_tx_hold = avs_writedata[7:0];
            next_tx_full = 1'b1;
        end
        if (tx_done) begin
            next_tx_full = 1'b0;
        end
        if (rd_go && reg_hit(avs_address, `UWBS_DATA_IDX)) begin
            next_rx_full = 1'b0;
        end
        // Hardware events win over a clear in the same cycle.
        if (rx_done) begin
            next_rx_full = 1'b1;
        end
        if (tx_done) begin
            next_evt[`UWBS_EVT_TXDONE_BIT] = 1'b1;
        end
        if (rx_done) begin
            next_evt[`UWBS_EVT_RXDONE_BIT] = 1'b1;
        end
        if (!port_en) begin
            next_tx_full = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack <= 1'b0;
            control <= 5'(`UWBS_CTRL_RESET);
            tx_hold <= 8'h00;
            mask <= 2'b00;
            avs_readdata <= 32'h0000_0000;
            tx_full <= 1'b0;
            rx_full <= 1'b0;
            evt <= 2'b00;
        end else begin
            ack <= next_ack;
            control <= next_control;
            tx_hold <= next_tx_hold;
            mask <= next_mask;
            avs_readdata <= next_readdata;
            tx_full <= next_tx_full;
            rx_full <= next_rx_full;
            evt <= next_evt;
        end
    end

    assign cpu_irq_rx_full = serial_irq_enable & rx_full;
    assign cpu_irq_tx_empty = serial_irq_enable & port_en & ~tx_full;
    assign irq = |(evt & mask);

    // ------------------------------------------------------------------------
    // Rate generator and receiver
    // ------------------------------------------------------------------------
    uwbs_baud_gen #(
        .CLK_HZ(CLK_HZ)
    ) u_baud (
        .ref_clk(ref_clk),
        .rst(rst),
        .enable(port_en),
        .rate_code(control[3:1]),
        .divide_by_eight_select(control[`UWBS_CTRL_DIVIDE_BY_EIGHT_SELECT_BIT]),
        .tick(tick)
    );

    uwbs_rx u_rx (
        .ref_clk(ref_clk),
        .rst(rst),
        .enable(port_en),
        .tick(tick),
        .rx_line(general_pin_receive_side_in),
        .rx_byte(rx_byte),
        .rx_done(rx_done)
    );

    // ------------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------------
    uwbs_state_type tx_state;
    uwbs_state_type next_tx_state;
    logic [3:0] tx_cnt;
    logic [3:0] next_tx_cnt;
    logic [2:0] tx_bit;
    logic [2:0] next_tx_bit;
    logic tx_line;
    logic next_tx_line;
    logic next_tx_done;

    always_comb begin
        next_tx_state = tx_state;
        next_tx_cnt = tx_cnt;
        next_tx_bit = tx_bit;
        next_tx_line = tx_line;
        next_tx_done = 1'b0;
        if (!port_en) begin
            next_tx_state = UWBS_IDLE;
            next_tx_line = 1'b1;
        end else if (tick) begin
            next_tx_cnt = 4'(tx_cnt + 4'h1);
            case (tx_state)
                UWBS_IDLE: begin
                    next_tx_cnt = 4'h0;
                    if (tx_full) begin
                        next_tx_state = UWBS_START;
                        next_tx_line = 1'b0;
                    end
                end
                UWBS_START: begin
                    if (tx_cnt == 4'hf) begin
                        next_tx_state = UWBS_DATA;
                        next_tx_bit = 3'h0;
                        next_tx_line = tx_hold[0];
                    end
                end
                UWBS_DATA: begin
                    if (tx_cnt == 4'hf) begin
                        next_tx_bit = 3'(tx_bit + 3'h1);
                        next_tx_line = tx_hold[3'(tx_bit + 3'h1)];
                        if (tx_bit == 3'h7) begin
                            next_tx_state = UWBS_STOP;
                            next_tx_line = 1'b1;
                        end
                    end
                end
                UWBS_STOP: begin
                    if (tx_cnt == 4'hf) begin
                        next_tx_state = UWBS_IDLE;
                        next_tx_done = 1'b1;
                    end
                end
                default: begin
                    next_tx_state = UWBS_IDLE;
                    next_tx_line = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_state <= UWBS_IDLE;
            tx_cnt <= 4'h0;
            tx_bit <= 3'h0;
            tx_line <= 1'b1;
            tx_done <= 1'b0;
            general_pin_transmit_side_out <= 1'b1;
            general_pin_transmit_side_oe <= 1'b0;
        end else begin
            tx_state <= next_tx_state;
            tx_cnt <= next_tx_cnt;
            tx_bit <= next_tx_bit;
            tx_line <= next_tx_line;
            tx_done <= next_tx_done;
            general_pin_transmit_side_out <= next_tx_line;
            general_pin_transmit_side_oe <= next_control[`UWBS_CTRL_EN_BIT];
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_disabled_releases;
        @(posedge ref_clk) disable iff (rst)
        !port_en |-> !general_pin_transmit_side_oe;
    endproperty
    a_disabled_releases: assert property (p_disabled_releases)
        else $error("Transmit pin driven while the port is off.");

    property p_write_sets_full;
        @(posedge ref_clk) disable iff (rst)
        (wr_go && avs_byteenable[0] && reg_hit(avs_address, `UWBS_DATA_IDX) && port_en)
            |=> tx_full;
    endproperty
    a_write_sets_full: assert property (p_write_sets_full)
        else $error("Data write did not set transmit-full.");

    property p_full_clears_after_stop;
        @(posedge ref_clk) disable iff (rst)
        tx_done |=> !tx_full;
    endproperty
    a_full_clears_after_stop: assert property (p_full_clears_after_stop)
        else $error("Transmit-full did not clear after the stop bit.");

    property p_full_while_sending;
        @(posedge ref_clk) disable iff (rst)
        (tx_state != UWBS_IDLE && port_en) |-> tx_full;
    endproperty
    a_full_while_sending: assert property (p_full_while_sending)
        else $error("Transmit-full low while a byte is on the line.");

    property p_read_clears_rx;
        @(posedge ref_clk) disable iff (rst)
        (rd_go && reg_hit(avs_address, `UWBS_DATA_IDX) && !rx_done) |=> !rx_full;
    endproperty
    a_read_clears_rx: assert property (p_read_clears_rx)
        else $error("Data read did not clear receive-full.");

    property p_rx_sets_full;
        @(posedge ref_clk) disable iff (rst)
        rx_done |=> rx_full && cpu_irq_rx_full == serial_irq_enable;
    endproperty
    a_rx_sets_full: assert property (p_rx_sets_full)
        else $error("Received byte did not raise receive-full.");

    property p_status_clean;
        @(posedge ref_clk) disable iff (rst)
        (rd_go && reg_hit(avs_address, `UWBS_STAT_IDX)) |->
            avs_readdata == {30'h0000_0000, $past(rx_full), $past(tx_full)};
    endproperty
    a_status_clean: assert property (p_status_clean)
        else $error("Status read shows more than the two flags.");

    property p_start_bit_low;
        @(posedge ref_clk) disable iff (rst)
        (tx_state == UWBS_START) |-> !tx_line;
    endproperty
    a_start_bit_low: assert property (p_start_bit_low)
        else $error("Start bit not held low.");

    property p_reset_value;
        @(posedge ref_clk) disable iff (rst)
        $past(rst) |-> control == 5'(`UWBS_CTRL_RESET);
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("Control register reset value wrong.");
endmodule

// ---- tb/uwbs_serial_peer.sv ----
// Model of the serial device on the far side of the port's two pins.
// Assumes both lines are synchronous to ref_clk and idle high.
`timescale 1ns/1ps

module uwbs_serial_peer (
    input wire logic ref_clk,
    input wire logic tx_line,
    output logic rx_line
);
    logic [7:0] got_byte;
    logic got_stop;
    int unsigned got_width;

    initial begin
        rx_line = 1'b1;
    end

    // The start bit is timed up to the first rise, so the byte sent must have bit 0 set.
    task automatic take(input int unsigned limit);
        int unsigned n;
        n = 0;
        got_width = 0;
        while (tx_line !== 1'b0 && n < limit) begin
            @(posedge ref_clk);
            n++;
        end
        while (tx_line !== 1'b1 && n < limit) begin
            @(posedge ref_clk);
            n++;
            got_width++;
        end
        repeat (got_width / 2) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            got_byte[i] = tx_line;
            repeat (got_width) @(posedge ref_clk);
        end
        got_stop = tx_line;
    endtask

    task automatic send(input logic [7:0] b, input int unsigned width);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_line <= frame[i];
            repeat (width) @(posedge ref_clk);
        end
    endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench of the serial port: register tasks over Avalon-MM and a serial peer.
// Assumes the port answers every access with one wait state.
`timescale 1ns/1ps
`include "uwbs_consts.svh"

module tb;
    // A clock rate whose divisors are exact keeps every expected bit period an integer.
    localparam int CLK = 7372800;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [17:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic serial_irq_enable = 1'b1;
    logic irq5;
    logic irq4;
    logic irq;
    logic tx_out;
    logic tx_oe;
    logic rx_in;
    logic [15:0] st;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int baud [8] = '{`UWBS_BAUD_0, `UWBS_BAUD_1, `UWBS_BAUD_2, `UWBS_BAUD_3,
                     `UWBS_BAUD_4, `UWBS_BAUD_5, `UWBS_BAUD_6, `UWBS_BAUD_7};

    always #12.5 ref_clk = ~ref_clk;

    uwbs_top #(.CLK_HZ(CLK)) i_dut (
        .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .serial_irq_enable(serial_irq_enable),
        .cpu_irq_rx_full(irq5), .cpu_irq_tx_empty(irq4), .irq(irq),
        .general_pin_transmit_side_out(tx_out), .general_pin_transmit_side_oe(tx_oe),
        .general_pin_receive_side_in(rx_in)
    );

    uwbs_serial_peer peer (.ref_clk(ref_clk), .tx_line(tx_out), .rx_line(rx_in));

    // ------------------------------------------------------------------------
    // Bus access and comparison tasks
    // ------------------------------------------------------------------------
    task automatic access(input logic [15:0] idx, input logic wr, input logic [15:0] wd,
                          output logic [15:0] rd);
        @(posedge ref_clk);
        avs_address <= {idx, 2'b00};
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {16'h0000, wd};
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        rd = avs_readdata[15:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] wd);
        logic [15:0] unused;
        access(idx, 1'b1, wd, unused);
    endtask

    task automatic rdchk(input logic [15:0] idx, input logic [15:0] exp, input string what);
        logic [15:0] got;
        access(idx, 1'b0, 16'h0000, got);
        chk(what, exp, got);
    endtask

    task automatic results();
        if (num_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // The whole run needs about 40000 cycles; the ceiling leaves ample margin.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            results();
        end
    end

    // ------------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        rdchk(`UWBS_CTRL_IDX, 16'h0007, "control");
        rdchk(`UWBS_STAT_IDX, 16'h0000, "status");
        chk("tx_oe", 16'h0001, {15'h0, tx_oe});
        chk("tx_idle", 16'h0001, {15'h0, tx_out});
        chk("irq4", 16'h0001, {15'h0, irq4});
        rdchk(16'hc0e6, 16'h0000, "unmapped");
        wr(`UWBS_STAT_IDX, 16'h0003);
        rdchk(`UWBS_STAT_IDX, 16'h0000, "status_ro");
        wr(`UWBS_EVT_IDX, 16'h0003);
        // Every rate code undivided, then code 000 through the prescaler.
        for (int c = 0; c < 9; c++) begin
            wr(`UWBS_CTRL_IDX, {11'h000, c == 8, c[2:0] & 3'(c < 8 ? 7 : 0), 1'b1});
            fork
                peer.take(20000);
                begin
                    wr(`UWBS_DATA_IDX, 16'h00a5);
                    rdchk(`UWBS_STAT_IDX, 16'h0001, "tx_full");
                    chk("irq4_busy", 16'h0000, {15'h0, irq4});
                end
            join
            chk("bit_cycles", 16'((CLK / baud[c % 8]) * (c == 8 ? 8 : 1)), 16'(peer.got_width));
            chk("tx_byte", 16'h00a5, {8'h00, peer.got_byte});
            chk("tx_stop", 16'h0001, {15'h0, peer.got_stop});
            st = 16'h0001;
            for (int n = 0; n < 2000 && st[0] !== 1'b0; n++) access(`UWBS_STAT_IDX, 1'b0, 0, st);
            chk("tx_empty", 16'h0000, st);
            chk("irq4_empty", 16'h0001, {15'h0, irq4});
        end
        wr(`UWBS_CTRL_IDX, 16'h0001);
        wr(`UWBS_MASK_IDX, 16'h0002);
        peer.send(8'h3c, CLK / baud[0]);
        repeat (CLK / baud[0]) @(posedge ref_clk);
        rdchk(`UWBS_STAT_IDX, 16'h0002, "rx_full");
        chk("irq5", 16'h0001, {15'h0, irq5});
        chk("irq", 16'h0001, {15'h0, irq});
        rdchk(`UWBS_DATA_IDX, 16'h003c, "rx_byte");
        rdchk(`UWBS_STAT_IDX, 16'h0000, "rx_cleared");
        chk("irq5_off", 16'h0000, {15'h0, irq5});
        rdchk(`UWBS_EVT_IDX, 16'h0003, "events");
        wr(`UWBS_EVT_IDX, 16'h0003);
        rdchk(`UWBS_EVT_IDX, 16'h0000, "events_clr");
        chk("irq_off", 16'h0000, {15'h0, irq});
        wr(`UWBS_CTRL_IDX, 16'h0000);
        // The enable drops at the accepting edge, so look one edge later.
        @(posedge ref_clk);
        chk("tx_oe_off", 16'h0000, {15'h0, tx_oe});
        wr(`UWBS_DATA_IDX, 16'h0055);
        rdchk(`UWBS_STAT_IDX, 16'h0000, "tx_dropped");
        chk("irq4_off", 16'h0000, {15'h0, irq4});
        results();
    end
endmodule
